// >>> logic/ossl_strap_loader.sv
`timescale 1ns/1ps
`include "ossl_defs.svh"

module ossl_strap_loader #(
   parameter int SAMPLE_CYC = `OSSL_SAMPLE_CYC, // Sampling window length in cycles
   parameter longint DELAY_CYC = `OSSL_DELAY_CYC, // Cycles per ID step of start delay
   parameter int ID_W = 4 // Bus ID width
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [ID_W-1:0] busIdPin_n,
   input wire logic delayedStartStrap_n,
   input wire logic motorStartOnCommandStrap_n,
   input wire logic writeProtectStrap_n,
   input wire logic parityCheckDisableStrap_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [ID_W-1:0] busId,
   output logic strapsLatched,
   output logic spindleRun,
   output logic writeProtect,
   output logic parityCheckEnable,
   output logic parityReportEnable
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (ID_W < 1 || ID_W > 4) begin : g_bad_id
      $error("ID_W must be 1 to 4");
   end
   if (SAMPLE_CYC < 1 || DELAY_CYC < 1) begin : g_bad_cnt
      $error("Counts must be at least one");
   end

   localparam int PINS = ID_W + 4;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PINS-1:0] pinRaw;  // Pins gathered for crossing
   logic [PINS-1:0] pinSync; // Pins after two flops

   // The host or jumpers drive these; treat as asynchronous
   assign pinRaw = {parityCheckDisableStrap_n, writeProtectStrap_n,
                    motorStartOnCommandStrap_n, delayedStartStrap_n, busIdPin_n};

   ossl_sync2 #(
      .WIDTH(PINS)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pinIn(pinRaw),
      .pinOut(pinSync)
   );

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Start policy from the two straps; command strap wins
   function automatic ossl_pkg::ossl_policy_t policyOf(input logic ds, input logic me);
      if (me) begin
         policyOf = ossl_pkg::OSSL_POL_COMMAND;
      end else if (ds) begin
         policyOf = ossl_pkg::OSSL_POL_DELAYED;
      end else begin
         policyOf = ossl_pkg::OSSL_POL_IMMEDIATE;
      end
   endfunction

   // Register address match
   function automatic logic addrIs(input logic [11:0] a, input logic [11:0] r);
      addrIs = (a == r);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      ossl_pkg::ossl_state_t state;      // Sequencer state
      logic [31:0] sampleCnt;            // Cycles left in ID window
      logic [ID_W-1:0] idAcc;            // ID bits seen asserted in window
      logic [ID_W-1:0] id;               // Latched bus ID
      logic ds;                          // Latched delayed-start strap
      logic me;                          // Latched command-start strap
      logic wp;                          // Latched write-protect strap
      logic pd;                          // Latched parity-disable strap
      logic latched;                     // Straps are frozen
      logic [63:0] delayCnt;             // Cycles left before spin-up
      logic spin;                        // Spindle run request
      logic parEn;                       // Parity check and report enable
      logic [31:0] rdata;                // APB read data
      logic ready;                       // APB ready
      logic err;                         // APB error
   } ossl_state_rec_t;

   ossl_state_rec_t st_q;
   ossl_state_rec_t st_d;

   logic [ID_W-1:0] idNow;      // Active-high view of the ID pins
   logic access;                // APB access phase, first cycle
   logic startCmd;              // Software wrote Start Unit
   logic stopCmd;               // Software wrote Stop Unit
   ossl_pkg::ossl_policy_t pol; // Policy from latched straps

   assign idNow = ~pinSync[ID_W-1:0]; // Pins are active low
   // Answer one cycle after penable rises; ready drops between transfers
   // The write commits at the taking edge; the master cannot abort an
   // access phase once penable is up, so nothing is lost by that
   assign access = psel && penable && !st_q.ready;
   assign startCmd = access && pwrite && addrIs(paddr, `OSSL_REG_CTRL) &&
                     pwdata[`OSSL_CTRL_START_BIT];
   assign stopCmd = access && pwrite && addrIs(paddr, `OSSL_REG_CTRL) &&
                    pwdata[`OSSL_CTRL_STOP_BIT];
   assign pol = policyOf(st_q.ds, st_q.me);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.ready = 1'b0;
      st_d.err = 1'b0;
      case (st_q.state)
         // Collect the ID over the whole window; a bit counts if seen low
         // The synchroniser resets to the idle high level, so the two
         // flush cycles at the window start never count as asserted
         ossl_pkg::OSSL_ST_SAMPLE: begin
            st_d.idAcc = st_q.idAcc | idNow;
            if (st_q.sampleCnt <= 32'd1) begin
               // Freeze every strap once; later pin changes are ignored
               st_d.id = st_q.idAcc | idNow;
               st_d.ds = !pinSync[ID_W];
               st_d.me = !pinSync[ID_W+1];
               st_d.wp = !pinSync[ID_W+2];
               st_d.pd = !pinSync[ID_W+3];
               st_d.latched = 1'b1;
               // A 64-bit count keeps ID 15 at the full step without overflow
               st_d.delayCnt = DELAY_CYC * 64'(st_q.idAcc | idNow);
               st_d.state = ossl_pkg::OSSL_ST_WAIT;
            end else begin
               st_d.sampleCnt = st_q.sampleCnt - 32'd1;
            end
         end
         // Apply the frozen start policy
         ossl_pkg::OSSL_ST_WAIT: begin
            case (pol)
               ossl_pkg::OSSL_POL_IMMEDIATE: begin
                  st_d.state = ossl_pkg::OSSL_ST_SPIN;
               end
               ossl_pkg::OSSL_POL_DELAYED: begin
                  // ID zero has a zero count, so it starts at once
                  if (st_q.delayCnt == 64'd0) begin
                     st_d.state = ossl_pkg::OSSL_ST_SPIN;
                  end else begin
                     st_d.delayCnt = st_q.delayCnt - 64'd1;
                  end
               end
               default: begin
                  st_d.state = ossl_pkg::OSSL_ST_STOPPED;
               end
            endcase
         end
         // Spinning; a Stop Unit parks the spindle
         ossl_pkg::OSSL_ST_SPIN: begin
            if (stopCmd) begin
               st_d.state = ossl_pkg::OSSL_ST_STOPPED;
            end
         end
         // Stopped until Start Unit arrives
         ossl_pkg::OSSL_ST_STOPPED: begin
            if (startCmd) begin
               st_d.state = ossl_pkg::OSSL_ST_SPIN;
            end
         end
         default: begin
            st_d.state = ossl_pkg::OSSL_ST_SAMPLE;
         end
      endcase
      st_d.spin = (st_d.state == ossl_pkg::OSSL_ST_SPIN);
      // Registered so the parity enables leave the block straight from a flop
      st_d.parEn = st_d.latched && !st_d.pd;

      // APB slave: answers in the second access cycle
      if (access) begin
         st_d.ready = 1'b1;
         st_d.rdata = 32'h0000_0000;
         if (addrIs(paddr, `OSSL_REG_CTRL)) begin
            st_d.rdata = 32'h0000_0000; // Command bits are write-only
         end else if (addrIs(paddr, `OSSL_REG_STATUS) && !pwrite) begin
            st_d.rdata[`OSSL_ST_LATCHED_BIT] = st_q.latched;
            st_d.rdata[`OSSL_ST_SPIN_BIT] = st_q.spin;
            st_d.rdata[`OSSL_ST_WP_BIT] = st_q.wp;
            st_d.rdata[`OSSL_ST_PARITY_BIT] = !st_q.pd;
            st_d.rdata[`OSSL_ST_STATE_LSB +: 2] = st_q.state;
            st_d.rdata[`OSSL_ST_ID_LSB +: ID_W] = st_q.id;
         end else if (addrIs(paddr, `OSSL_REG_STRAPS) && !pwrite) begin
            st_d.rdata[3:0] = {st_q.pd, st_q.wp, st_q.me, st_q.ds};
         end else begin
            st_d.err = 1'b1; // Unmapped, or write to read-only
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.state <= ossl_pkg::OSSL_ST_SAMPLE;
         st_q.sampleCnt <= 32'(SAMPLE_CYC);
         st_q.id <= ID_W'(`OSSL_RST_ID);
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flops
   // ---------------------------------------------------------------
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.err;
   assign busId = st_q.id;
   assign strapsLatched = st_q.latched;
   assign spindleRun = st_q.spin;
   assign writeProtect = st_q.wp;
   // Parity checks only once straps are frozen and not disabled
   assign parityCheckEnable = st_q.parEn;
   assign parityReportEnable = st_q.parEn;

endmodule // ossl_strap_loader

// >>> inc/ossl_defs.svh
`ifndef OSSL_DEFS_SVH
`define OSSL_DEFS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OSSL_CLK_HZ 100000000
`define OSSL_SAMPLE_MS 250
`define OSSL_SAMPLE_CYC ((`OSSL_CLK_HZ / 1000) * `OSSL_SAMPLE_MS)
`define OSSL_DELAY_SEC 12
`define OSSL_DELAY_CYC (`OSSL_CLK_HZ * `OSSL_DELAY_SEC)

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OSSL_REG_CTRL 12'h000
`define OSSL_REG_STATUS 12'h004
`define OSSL_REG_STRAPS 12'h008

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OSSL_CTRL_START_BIT 0
`define OSSL_CTRL_STOP_BIT 1
`define OSSL_ST_LATCHED_BIT 0
`define OSSL_ST_SPIN_BIT 1
`define OSSL_ST_WP_BIT 2
`define OSSL_ST_PARITY_BIT 3
`define OSSL_ST_STATE_LSB 4
`define OSSL_ST_ID_LSB 8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define OSSL_RST_ID 4'h0

`endif

// >>> inc/ossl_pkg.sv
package ossl_pkg;

   // Spindle start policy decoded from the two start straps
   typedef enum logic [1:0] {
      OSSL_POL_IMMEDIATE = 2'h0,
      OSSL_POL_DELAYED = 2'h1,
      OSSL_POL_COMMAND = 2'h2
   } ossl_policy_t;

   // Sequencer states, Gray coded along sample, wait, spin
   typedef enum logic [1:0] {
      OSSL_ST_SAMPLE = 2'h0,
      OSSL_ST_WAIT = 2'h1,
      OSSL_ST_SPIN = 2'h3,
      OSSL_ST_STOPPED = 2'h2
   } ossl_state_t;

endpackage

// >>> logic/ossl_sync2.sv
`timescale 1ns/1ps

// Two flip-flop synchroniser for a bundle of pin levels
module ossl_sync2 #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;   // First stage, read only by second
      logic [WIDTH-1:0] stable; // Second stage, safe to use
   } ossl_sync_t;

   ossl_sync_t sync_q;
   ossl_sync_t sync_d;

   // Shift the pins through both stages
   always_comb begin
      sync_d.meta = pinIn;
      sync_d.stable = sync_q.meta;
   end

   // Register the stages; reset to the idle high level of active-low pins
   // so no pin looks asserted while the stages flush after reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_q <= '1;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign pinOut = sync_q.stable;

endmodule // ossl_sync2

// >>> testbench/ossl_strap_plugs.sv
`timescale 1ns/1ps

// ------------------------------
// Jumper plugs or host adapter
// ------------------------------
module ossl_strap_plugs (
   input wire logic [3:0] idSet, // Wanted ID, active high
   input wire logic [3:0] strapSet, // Installed: ds, me, wp, pd
   input wire logic idHeld, // Host still asserts the ID
   output logic [3:0] busIdPin_n,
   output logic [3:0] strapPin_n
);
   // A released ID line goes to its pull-up, so it reads as not asserted
   assign busIdPin_n = idHeld ? ~idSet : 4'hf;
   // Host drives the start strap levels where no jumper fits
   assign strapPin_n = ~strapSet;
endmodule // ossl_strap_plugs

// >>> testbench/ossl_strap_loader_assertions.sv
`timescale 1ns/1ps

// ------------------------------
// Checker on the loader ports
// ------------------------------
module ossl_strap_loader_assertions #(
   parameter int SAMPLE_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [3:0] busId,
   input wire logic strapsLatched,
   input wire logic spindleRun,
   input wire logic writeProtect,
   input wire logic parityCheckEnable,
   input wire logic parityReportEnable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   int cycCnt_q; // Edges since reset release, saturating
   // Counter restarts at every reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cycCnt_q <= 0;
      end else if (cycCnt_q < 100000) begin
         cycCnt_q <= cycCnt_q + 1;
      end
   end
   sequence sApbTake;
      psel && penable && !pready;
   endsequence
   sequence sSettled;
      strapsLatched && $stable(busId);
   endsequence
   AST_WINDOW_END: assert property ($rose(strapsLatched) |-> cycCnt_q >= SAMPLE_CYC && cycCnt_q <= SAMPLE_CYC + 4) else $error("latch moment off");
   AST_NO_EARLY: assert property (cycCnt_q < SAMPLE_CYC |-> !strapsLatched) else $error("latched early");
   AST_ID_HOLD: assert property (strapsLatched |=> sSettled) else $error("bus id moved");
   AST_OPT_HOLD: assert property (strapsLatched |=> $stable(writeProtect) && $stable(parityCheckEnable)) else $error("option moved");
   AST_PAR_PAIR: assert property (parityCheckEnable == parityReportEnable) else $error("parity pair split");
   AST_PAR_LATCH: assert property (parityCheckEnable |-> strapsLatched) else $error("parity before latch");
   AST_WP_LATCH: assert property (writeProtect |-> strapsLatched) else $error("protect before latch");
   AST_SPIN_LATCH: assert property (spindleRun |-> strapsLatched) else $error("spin before latch");
   AST_APB_ANSWER: assert property (sApbTake |=> pready ##1 !pready) else $error("apb answer wrong");
endmodule // ossl_strap_loader_assertions

bind ossl_strap_loader ossl_strap_loader_assertions #(.SAMPLE_CYC(SAMPLE_CYC)) i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready), .busId(busId), .strapsLatched(strapsLatched), .spindleRun(spindleRun), .writeProtect(writeProtect), .parityCheckEnable(parityCheckEnable), .parityReportEnable(parityReportEnable));

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, idHeld = 1;
   logic pready, pslverr, strapsLatched, spindleRun, writeProtect, errSeen;
   logic parityCheckEnable, parityReportEnable;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic [3:0] busId, idSet = 4'h0, strapSet = 4'h0, busIdPin_n, strapPin_n;
   int err_total = 0, samples_checked = 0;
   // Clock: 100 MHz
   always #5 sys_clk = ~sys_clk;
   // Short window and delay step keep the run brief
   ossl_strap_loader #(.SAMPLE_CYC(20), .DELAY_CYC(10)) i_ossl_strap_loader (.sys_clk(sys_clk),
      .reset_n(reset_n), .busIdPin_n(busIdPin_n), .delayedStartStrap_n(strapPin_n[0]),
      .motorStartOnCommandStrap_n(strapPin_n[1]), .writeProtectStrap_n(strapPin_n[2]),
      .parityCheckDisableStrap_n(strapPin_n[3]), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busId(busId), .strapsLatched(strapsLatched), .spindleRun(spindleRun),
      .writeProtect(writeProtect), .parityCheckEnable(parityCheckEnable),
      .parityReportEnable(parityReportEnable));
   ossl_strap_plugs i_ossl_strap_plugs (.idSet(idSet), .strapSet(strapSet), .idHeld(idHeld),
      .busIdPin_n(busIdPin_n), .strapPin_n(strapPin_n));
   // ------------------------------
   // Shared helpers
   // ------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      @(posedge sys_clk);
      psel <= 1; pwrite <= wr; paddr <= addr; pwdata <= data;
      @(posedge sys_clk);
      penable <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         chk("apbTimeout", 1, 0);
         end_sim();
      end
      rdData = prdata; errSeen = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // ------------------------------
   // Scenario: one strap setting
   // ------------------------------
   task automatic t_policy(input logic [3:0] st, input logic [3:0] id);
      int n, d;
      reset_n <= 0; strapSet <= st; idSet <= id; idHeld <= 1;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1;
      for (n = 0; n < 40 && strapsLatched !== 1'b1; n++) @(posedge sys_clk);
      chk("latchCycles", n >= 20 && n <= 24, 1);
      if (n == 40) end_sim();
      idHeld <= 0; // Host lets go once the window has ended
      chk("busId", busId, id);
      chk("writeProtect", writeProtect, st[2]);
      chk("parityCheck", parityCheckEnable, !st[3]);
      chk("parityReport", parityReportEnable, !st[3]);
      if (st[1]) begin
         repeat (60) @(posedge sys_clk);
         chk("spinBeforeCmd", spindleRun, 0);
         apb(1, 12'h000, 32'h1);
         repeat (4) @(posedge sys_clk);
         chk("spinAfterCmd", spindleRun, 1);
      end else begin
         d = st[0] ? id * 10 : 0;
         for (n = 0; n < 250 && spindleRun !== 1'b1; n++) @(posedge sys_clk);
         chk("spinDelay", n >= d && n <= d + 4, 1);
         if (n == 250) end_sim();
      end
      // Straps moved while powered must change nothing
      strapSet <= ~st; idSet <= ~id; idHeld <= 1;
      repeat (30) @(posedge sys_clk);
      chk("idKept", busId, id);
      chk("wpKept", writeProtect, st[2]);
      chk("spinKept", spindleRun, 1);
      $display("policy %h id %h done", st, id);
   endtask
   // ------------------------------
   // Scenario: registers after both straps, wp and pd
   // ------------------------------
   task automatic t_regs();
      apb(0, 12'h004, 32'h0);
      chk("status", rdData, 32'h00000f37);
      apb(0, 12'h008, 32'h0);
      chk("strapsReg", rdData, 32'h0000000f);
      apb(0, 12'h00c, 32'h0);
      chk("unmappedErr", errSeen, 1);
      apb(1, 12'h004, 32'hffffffff);
      chk("roWriteErr", errSeen, 1);
      apb(0, 12'h000, 32'h0);
      chk("ctrlRead", rdData, 32'h0);
      chk("ctrlReadErr", errSeen, 0);
      apb(1, 12'h000, 32'h2);
      repeat (4) @(posedge sys_clk);
      chk("spinStopped", spindleRun, 0);
      $display("register test done");
   endtask
   initial begin
      t_policy(4'b0000, 4'h5);
      t_policy(4'b0001, 4'h3);
      t_policy(4'b0001, 4'h0);
      t_policy(4'b0110, 4'ha);
      t_policy(4'b1111, 4'hf);
      t_regs();
      end_sim();
   end
endmodule // tb_top
